// ===== shared/ldwd_params.svh
// Constants of the load dependent window watchdog
`ifndef LDWD_PARAMS_SVH
`define LDWD_PARAMS_SVH
// Clock rate in kHz (25 MHz)
`define LDWD_CLK_KHZ 25000
// Times in milliseconds, as typical figures
`define LDWD_RD_SLOW_MS 16.5
`define LDWD_RD_FAST_MS 8.5
`define LDWD_IGNORE_MS 16
`define LDWD_FAIL_LOW_MS 8
`define LDWD_TRIG_LL_MS 96
`define LDWD_TRIG_HL_MS 48
`define LDWD_TRIG_LH_MS 32
`define LDWD_TRIG_HH_MS 16
// Load and disable filter time in microseconds
`define LDWD_FILTER_US 300
// Cycle counts derived from the times
`define LDWD_RD_SLOW_CYC ($rtoi(`LDWD_RD_SLOW_MS * `LDWD_CLK_KHZ))
`define LDWD_RD_FAST_CYC ($rtoi(`LDWD_RD_FAST_MS * `LDWD_CLK_KHZ))
`define LDWD_IGNORE_CYC (`LDWD_IGNORE_MS * `LDWD_CLK_KHZ)
`define LDWD_FAIL_LOW_CYC (`LDWD_FAIL_LOW_MS * `LDWD_CLK_KHZ)
`define LDWD_TRIG_LL_CYC (`LDWD_TRIG_LL_MS * `LDWD_CLK_KHZ)
`define LDWD_TRIG_HL_CYC (`LDWD_TRIG_HL_MS * `LDWD_CLK_KHZ)
`define LDWD_TRIG_LH_CYC (`LDWD_TRIG_LH_MS * `LDWD_CLK_KHZ)
`define LDWD_TRIG_HH_CYC (`LDWD_TRIG_HH_MS * `LDWD_CLK_KHZ)
`define LDWD_FILTER_CYC ((`LDWD_FILTER_US * `LDWD_CLK_KHZ) / 1000)
// Register offsets
`define LDWD_OFS_STATUS 4'h0
`define LDWD_OFS_MASK 4'h4
`define LDWD_OFS_STATE 4'h8
// Status and mask bit positions
`define LDWD_BIT_TIMEOUT 0
`define LDWD_BIT_ACT 1
`define LDWD_BIT_DEACT 2
// Reset values
`define LDWD_MASK_RST 3'h0
`endif

// ===== shared/ldwd_pkg.sv
// Types of the load dependent window watchdog
package ldwd_pkg;
    // Supervisor timer phases
    typedef enum logic [1:0] {
        LDWD_OFF,
        LDWD_IGNORE,
        LDWD_TRIGGER,
        LDWD_FAIL
    } ldwd_state_t;
endpackage

// ===== hw/ldwd_top.sv
// Load dependent window watchdog with power-on reset delay
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ldwd_params.svh"

module ldwd_top
    import ldwd_pkg::*;
#(
    parameter int RD_SLOW_CYC = `LDWD_RD_SLOW_CYC,
    parameter int RD_FAST_CYC = `LDWD_RD_FAST_CYC,
    parameter int IGNORE_CYC = `LDWD_IGNORE_CYC,
    parameter int FAIL_LOW_CYC = `LDWD_FAIL_LOW_CYC,
    parameter int TRIG_LL_CYC = `LDWD_TRIG_LL_CYC,
    parameter int TRIG_HL_CYC = `LDWD_TRIG_HL_CYC,
    parameter int TRIG_LH_CYC = `LDWD_TRIG_LH_CYC,
    parameter int TRIG_HH_CYC = `LDWD_TRIG_HH_CYC,
    parameter int FILTER_CYC = `LDWD_FILTER_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins from the microcontroller and board
    input wire logic trigger_in,
    input wire logic trigger_dis_in,
    input wire logic delay_sel_a,
    input wire logic delay_sel_b,
    input wire logic load_high_in,
    // Pins to the microcontroller
    output logic mcu_reset_out_n,
    output logic watchdog_fail_out_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt
    output logic irq
);

    // Width of the long counters, fits the longest window
    localparam int CW = 23;
    // Width of the filter counters
    localparam int FW = 16;
    // Synchroniser bit positions
    localparam int S_TRIG = 0;
    localparam int S_SELA = 1;
    localparam int S_SELB = 2;
    localparam int S_LOAD = 3;
    localparam int S_DIS = 4;

    // Whole state of the block
    typedef struct packed {
        logic [4:0] s1;          // First synchroniser stage
        logic [4:0] s2;          // Second synchroniser stage
        logic trig_prev;         // Trigger level one cycle back
        logic [CW-1:0] rd_cnt;   // Reset delay counter
        logic ro_n;              // Microcontroller reset, active low
        logic [FW-1:0] load_cnt; // Load filter counter
        logic load_f;            // Filtered high load
        logic [FW-1:0] dis_cnt;  // Disable filter counter
        logic dis_f;             // Filtered disable level
        logic active;            // Supervisor timer on
        ldwd_state_t st;         // Supervisor phase
        logic [CW-1:0] cnt;      // Phase counter
        logic [CW-1:0] win;      // Window length of this period
        logic wo_n;              // Fail output, active low
        logic [2:0] status;      // Sticky events
        logic [2:0] mask;        // Interrupt enables
        logic irq;               // Interrupt level
        logic [7:0] rdata;       // Read answer
    } ldwd_regs_t;

    ldwd_regs_t q;
    ldwd_regs_t d;

    // Window length selected by the straps
    function automatic logic [CW-1:0] win_sel(input logic a,
                                              input logic b);
        logic [CW-1:0] w;
        w = CW'(TRIG_HH_CYC);
        if (!a && !b) begin
            w = CW'(TRIG_LL_CYC);
        end else if (a && !b) begin
            w = CW'(TRIG_HL_CYC);
        end else if (!a && b) begin
            w = CW'(TRIG_LH_CYC);
        end
        return w;
    endfunction

    // One step of a persistence filter: output follows the input
    // only after it has differed for the whole filter time
    function automatic logic [FW:0] filt(input logic [FW-1:0] c,
                                         input logic f,
                                         input logic raw);
        logic [FW:0] r;
        r = {c, f};
        if (raw == f) begin
            r = {FW'(0), f};
        end else if (c == FW'(FILTER_CYC - 1)) begin
            r = {FW'(0), raw};
        end else begin
            r = {c + FW'(1), f};
        end
        return r;
    endfunction

    // Reset delay picked by the first strap
    logic [CW-1:0] rd_len;
    assign rd_len = q.s2[S_SELA] ? CW'(RD_FAST_CYC) : CW'(RD_SLOW_CYC);

    // Next state of the whole block
    always_comb begin
        logic fall;
        logic want;
        logic [2:0] ev;
        fall = 1'b0;
        want = 1'b0;
        d = q;
        ev = 3'h0;
        // Pins are read only after the second stage
        d.s1 = {trigger_dis_in, load_high_in, delay_sel_b,
                delay_sel_a, trigger_in};
        d.s2 = q.s1;
        d.trig_prev = q.s2[S_TRIG];
        fall = q.trig_prev && !q.s2[S_TRIG];

        // Power-on reset delay, held low until it runs out
        if (!q.ro_n) begin
            if (q.rd_cnt >= rd_len - CW'(1)) begin
                d.ro_n = 1'b1;
            end else begin
                d.rd_cnt = q.rd_cnt + CW'(1);
            end
        end

        // Load and disable level filters
        {d.load_cnt, d.load_f} = filt(q.load_cnt, q.load_f,
                                      q.s2[S_LOAD]);
        {d.dis_cnt, d.dis_f} = filt(q.dis_cnt, q.dis_f,
                                    q.s2[S_DIS]);
        // Timer runs only with high load, no disable, reset released
        want = q.load_f && !q.dis_f && q.ro_n;
        d.active = want;
        if (want && !q.active) begin
            ev[`LDWD_BIT_ACT] = 1'b1;
        end
        if (!want && q.active) begin
            ev[`LDWD_BIT_DEACT] = 1'b1;
        end

        // Supervisor phases
        d.cnt = q.cnt + CW'(1);
        case (q.st)
            LDWD_OFF: begin
                d.cnt = '0;
                if (want) begin
                    d.st = LDWD_IGNORE;
                end
            end
            LDWD_IGNORE: begin
                if (q.cnt == CW'(IGNORE_CYC - 1)) begin
                    d.st = LDWD_TRIGGER;
                    d.cnt = '0;
                    d.win = win_sel(q.s2[S_SELA], q.s2[S_SELB]);
                end
            end
            LDWD_TRIGGER: begin
                if (fall) begin
                    d.cnt = '0;
                    d.win = win_sel(q.s2[S_SELA], q.s2[S_SELB]);
                end else if (q.cnt == q.win - CW'(1)) begin
                    d.st = LDWD_FAIL;
                    d.cnt = '0;
                    ev[`LDWD_BIT_TIMEOUT] = 1'b1;
                end
            end
            LDWD_FAIL: begin
                if (q.cnt == CW'(FAIL_LOW_CYC - 1)) begin
                    d.st = LDWD_IGNORE;
                    d.cnt = '0;
                end
            end
            default: begin
                d.st = LDWD_OFF;
            end
        endcase
        // Switching off wins over any phase
        if (!want) begin
            d.st = LDWD_OFF;
            d.cnt = '0;
        end
        d.wo_n = (d.st != LDWD_FAIL);

        // Registers: clear by writing one, a new event wins
        d.rdata = 8'h00;
        if (reg_wr) begin
            if (reg_addr == `LDWD_OFS_STATUS) begin
                d.status = q.status & ~reg_wdata[2:0];
            end else if (reg_addr == `LDWD_OFS_MASK) begin
                d.mask = reg_wdata[2:0];
            end
        end
        d.status = d.status | ev;
        if (reg_rd) begin
            if (reg_addr == `LDWD_OFS_STATUS) begin
                d.rdata = {5'h00, q.status};
            end else if (reg_addr == `LDWD_OFS_MASK) begin
                d.rdata = {5'h00, q.mask};
            end else if (reg_addr == `LDWD_OFS_STATE) begin
                d.rdata = {1'b0, q.s2[S_SELB], q.s2[S_SELA], q.st,
                           q.wo_n, q.ro_n, q.active};
            end
        end
        d.irq = |(d.status & d.mask);
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
            q.st <= LDWD_OFF;
            q.wo_n <= 1'b1;
            q.mask <= `LDWD_MASK_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign mcu_reset_out_n = q.ro_n;
    assign watchdog_fail_out_n = q.wo_n;
    assign reg_rdata = q.rdata;
    assign irq = q.irq;

    // Falling edge seen by the phase logic
    logic fall_a;
    assign fall_a = q.trig_prev && !q.s2[S_TRIG];

    property p_timeout;
        @(posedge clk) disable iff (!reset_n)
        (q.st == LDWD_TRIGGER && !fall_a && q.cnt == q.win - CW'(1)
         && d.active) |=> !watchdog_fail_out_n;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("missed trigger did not pull fail output low");

    property p_retrigger;
        @(posedge clk) disable iff (!reset_n)
        (q.st == LDWD_TRIGGER && fall_a && d.active)
        |=> (q.cnt == '0 && q.st == LDWD_TRIGGER) ##1 q.cnt == CW'(1);
    endproperty
    a_retrigger: assert property (p_retrigger)
        else $error("trigger edge did not restart the window");

    property p_window_hold;
        @(posedge clk) disable iff (!reset_n)
        (q.st == LDWD_TRIGGER && !fall_a) |=> $stable(q.win);
    endproperty
    a_window_hold: assert property (p_window_hold)
        else $error("window length changed inside a period");

    property p_window_map;
        @(posedge clk) disable iff (!reset_n)
        // Expected length spelled out from the table, not from win_sel
        (q.st == LDWD_IGNORE && d.st == LDWD_TRIGGER)
        |=> q.win == ($past(q.s2[S_SELA])
                      ? ($past(q.s2[S_SELB]) ? CW'(TRIG_HH_CYC)
                                             : CW'(TRIG_HL_CYC))
                      : ($past(q.s2[S_SELB]) ? CW'(TRIG_LH_CYC)
                                             : CW'(TRIG_LL_CYC)));
    endproperty
    a_window_map: assert property (p_window_map)
        else $error("window length does not match the straps");

    property p_ignore_end;
        @(posedge clk) disable iff (!reset_n)
        (q.st == LDWD_IGNORE && q.cnt == CW'(IGNORE_CYC - 1) && d.active)
        |=> q.st == LDWD_TRIGGER && q.cnt == '0;
    endproperty
    a_ignore_end: assert property (p_ignore_end)
        else $error("ignore time did not lead to the window");

    property p_fail_release;
        @(posedge clk) disable iff (!reset_n)
        (q.st == LDWD_FAIL && q.cnt == CW'(FAIL_LOW_CYC - 1) && d.active)
        |=> watchdog_fail_out_n && q.st == LDWD_IGNORE && q.cnt == '0;
    endproperty
    a_fail_release: assert property (p_fail_release)
        else $error("fail low time did not end in the ignore time");

    property p_off_high;
        @(posedge clk) disable iff (!reset_n)
        !q.active |=> watchdog_fail_out_n || q.active;
    endproperty
    a_off_high: assert property (p_off_high)
        else $error("fail output low while the timer is off");

    property p_reset_hold;
        @(posedge clk) disable iff (!reset_n)
        // A strap change after release must not look like an early release
        (!mcu_reset_out_n && q.rd_cnt < rd_len - CW'(1))
        |=> !mcu_reset_out_n;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("mcu reset released before the delay ran out");

    property p_filter;
        @(posedge clk) disable iff (!reset_n)
        $changed(q.load_f) |-> $past(q.load_cnt) == FW'(FILTER_CYC - 1);
    endproperty
    a_filter: assert property (p_filter)
        else $error("load state changed before the filter time");

endmodule

// ===== test/ldwd_mcu_model.sv
// Microcontroller model that sends trigger edges at a set period
`timescale 1ns/1ps

module ldwd_mcu_model
    import ldwd_pkg::*;
(
    // Clock
    input wire logic clk,
    // Control from the bench
    input wire logic trig_en,
    input wire logic [15:0] trig_period,
    // Trigger pin
    output logic trigger_in
);
    logic [15:0] cnt_q; // Cycles since the last falling edge

    initial trigger_in = 1'b1;
    initial cnt_q = 16'h0000;

    // Pin idles high; each period it drops for four cycles, long enough
    // for the two-flop synchroniser to see it
    always @(posedge clk) begin
        if (!trig_en) begin
            cnt_q <= 16'h0000;
            trigger_in <= 1'b1;
        end else begin
            cnt_q <= (cnt_q + 16'h0001 >= trig_period) ? 16'h0000
                                                        : cnt_q + 16'h0001;
            trigger_in <= (cnt_q >= 16'h0004);
        end
    end
endmodule

// ===== test/ldwd_top_bench.sv
// Self-checking bench of the load dependent window watchdog
`timescale 1ns/1ps

module ldwd_top_bench
    import ldwd_pkg::*;
;
    // Shortened counts; index of the window table is {sel_b, sel_a}
    localparam int RDS = 50, RDF = 30, IGN = 20, FLO = 10, FILT = 8;
    localparam int WIN [4] = '{80, 60, 40, 30};
    logic clk = 1'b0, reset_n = 1'b0;
    logic trigger_dis_in = 1'b0, load_high_in = 1'b0;
    logic delay_sel_a = 1'b0, delay_sel_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, trig_en = 1'b0;
    logic [15:0] trig_period = 16'h0032; // 50 cycles, inside the 80 and 60 cycle windows
    logic trigger_in, mcu_reset_out_n, watchdog_fail_out_n, irq;
    logic [7:0] reg_rdata, d;
    int fail_count = 0, checks = 0, n;
    time t0;

    always #20 clk = ~clk;

    ldwd_top #(.RD_SLOW_CYC(RDS), .RD_FAST_CYC(RDF), .IGNORE_CYC(IGN),
        .FAIL_LOW_CYC(FLO), .TRIG_LL_CYC(WIN[0]), .TRIG_HL_CYC(WIN[1]),
        .TRIG_LH_CYC(WIN[2]), .TRIG_HH_CYC(WIN[3]), .FILTER_CYC(FILT)
    ) u_dut (.clk(clk), .reset_n(reset_n), .trigger_in(trigger_in),
        .trigger_dis_in(trigger_dis_in), .delay_sel_a(delay_sel_a),
        .delay_sel_b(delay_sel_b), .load_high_in(load_high_in),
        .mcu_reset_out_n(mcu_reset_out_n),
        .watchdog_fail_out_n(watchdog_fail_out_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    ldwd_mcu_model u_mcu (.clk(clk), .trig_en(trig_en),
        .trig_period(trig_period), .trigger_in(trigger_in));

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chb(input logic seen, input logic exp);
        chk({7'h00, seen}, {7'h00, exp});
    endtask

    // Register bus cycles; read data stand only in the cycle after
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask

    // Count settled cycles until the fail output shows a level, bounded
    task automatic wait_fail(input logic v, input int lim, output int c);
        c = 0;
        while (watchdog_fail_out_n !== v && c < lim) begin
            @(negedge clk);
            c++;
        end
    endtask

    // Power-on reset and the strap-chosen reset delay
    task automatic do_reset(input logic a, input int rdc);
        @(posedge clk);
        reset_n <= 1'b0;
        delay_sel_a <= a;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chb(mcu_reset_out_n, 1'b0);
        chb(watchdog_fail_out_n, 1'b1);
        chb(irq, 1'b0);
        n = 0;
        while (mcu_reset_out_n !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chb(n inside {[rdc - 2:rdc + 3]}, 1'b1);
        rd(4'h4, d);
        chk(d, 8'h00);
    endtask

    // A short load pulse is filtered out, a held one activates
    task automatic activate();
        @(posedge clk);
        load_high_in <= 1'b1;
        repeat (3) @(posedge clk);
        load_high_in <= 1'b0;
        repeat (20) @(posedge clk);
        rd(4'h8, d);
        chb(d[0], 1'b0);
        @(posedge clk);
        load_high_in <= 1'b1;
        repeat (4) @(posedge clk);
        rd(4'h8, d);
        chb(d[0], 1'b0);
        repeat (8) @(posedge clk);
        rd(4'h8, d);
        chk({4'h0, d[4:2], d[0]}, 8'h07);
        rd(4'h0, d);
        chb(d[1], 1'b1);
    endtask

    // Every strap code: ignore time, window length and fixed low time
    task automatic windows();
        wait_fail(1'b0, 300, n);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {delay_sel_b, delay_sel_a} <= 2'(i);
            wait_fail(1'b1, 100, n);
            chb(n inside {[FLO - 1:FLO + 1]}, 1'b1);
            wait_fail(1'b0, 300, n);
            chb(n inside {[IGN + WIN[i] - 1:IGN + WIN[i] + 3]}, 1'b1);
        end
    endtask

    // Regular triggers keep the output high; a strap change mid-period
    // must not shorten the running window
    task automatic retrigger();
        @(posedge clk);
        {delay_sel_b, delay_sel_a} <= 2'b00;
        trig_en <= 1'b1;
        wait_fail(1'b1, 100, n);
        wait_fail(1'b0, 300, n);
        chb(n == 300, 1'b1);
        @(negedge trigger_in);
        t0 = $time;
        trig_en <= 1'b0;
        repeat (6) @(posedge clk);
        {delay_sel_b, delay_sel_a} <= 2'b11;
        wait_fail(1'b0, 200, n);
        chb((($time - t0) / 40) inside {[80:88]}, 1'b1);
    endtask

    // Sticky status, mask, level interrupt and an unmapped place
    task automatic interrupts();
        rd(4'h0, d);
        chb(d[0], 1'b1);
        chb(irq, 1'b0);
        wr(4'h4, 8'h01);
        @(negedge clk);
        chb(irq, 1'b1);
        wr(4'h0, 8'h07);
        @(negedge clk);
        chb(irq, 1'b0);
        wr(4'hc, 8'hff);
        rd(4'hc, d);
        chk(d, 8'h00);
    endtask

    // Low load deactivates only after the filter; a held disable level keeps the timer off
    task automatic deactivate();
        @(posedge clk);
        load_high_in <= 1'b0;
        repeat (4) @(posedge clk);
        rd(4'h8, d);
        chb(d[0], 1'b1);
        repeat (10) @(posedge clk);
        rd(4'h8, d);
        chb(d[0], 1'b0);
        wait_fail(1'b0, 300, n);
        chb(n == 300, 1'b1);
        @(posedge clk);
        trigger_dis_in <= 1'b1;
        load_high_in <= 1'b1;
        repeat (30) @(posedge clk);
        rd(4'h8, d);
        chb(d[0], 1'b0);
        @(posedge clk);
        trigger_dis_in <= 1'b0;
        repeat (16) @(posedge clk);
        rd(4'h8, d);
        chb(d[0], 1'b1);
    endtask

    // Verdict, reached from the main sequence or the watchdog
    task automatic conclude();
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence; the second reset lands while the watchdog runs
    initial begin
        do_reset(1'b0, RDS);
        activate();
        windows();
        retrigger();
        interrupts();
        deactivate();
        do_reset(1'b1, RDF);
        conclude();
    end

    // Run should take under 10000 cycles
    initial begin
        #400000;
        fail_count++;
        conclude();
    end
endmodule
